// ===== pio_port_bank.sv
// Purpose: Nine-port parallel I/O bank with alternate function hand-off
// Assumes: Software access port on the same clock; pads asynchronous
// Notes: Access takes one cycle; done and read data come one edge later
// How it works
// - Every pin level is latched each state time, input or output.
// - Write to input pin stores latch only; read returns sampled pin.
// - Input pin read-modify-write sources pin, result goes to latch.
// - Direction one drives pin from latch; read returns latch.
// - Output pin read-modify-write sources latch, writes latch back.
// - Ports 2,3,4,6,7,8 select push-pull or open-drain per bit.
// - Inputs default TTL; threshold control selects CMOS per byte.
// - One threshold bit per byte; 16-bit ports 2,3,5 use two.
// - Direction and drive mode ignore the selected input threshold.
// - Alternate output reaches pin only with output direction.
// - Driven level is latch AND alternate data, except PWM lines.
// - All direction bits reset to input.
// - Alternate input sees output latch when pin is an output.
// - Hardware switches direction while a bus function owns pins.
// - Port 3 has fifteen lines; bit 14 has no pin.
// - Port 5 is sixteen input-only lines without drivers.
// - Ports 0 and 1 are two separately addressed byte halves.
// - Each line carries exactly one alternate input or output.
`timescale 1ns/1ps
`include "pio_consts.svh"

module pio_port_bank
(
    input wire logic clk,
    input wire logic arst_n,
    // Pads, one 16-bit slot per unit
    input wire logic [15:0] pad_in [0:10],
    output logic [15:0] pad_out_r [0:10],
    output logic [15:0] pad_oe_r [0:10],
    // Per-byte CMOS threshold select to the pad ring
    output logic [1:0] cmos_sel_r [0:10],
    // Threshold controls
    input wire logic [7:0] input_threshold_select,
    input wire logic [5:0] ext_input_threshold_select,
    // Software access
    input wire logic acc_valid,
    input wire logic [3:0] acc_unit,
    input wire pio_pkg::acc_kind_type acc_kind,
    input wire pio_pkg::acc_op_type acc_op,
    input wire logic [15:0] acc_wdata,
    input wire logic [15:0] acc_and_mask,
    output logic [15:0] acc_rdata_r,
    output logic acc_done_r,
    // Alternate functions, one per line
    input wire logic [15:0] alt_out_en [0:10],
    input wire logic [15:0] alt_out_data [0:10],
    input wire logic [15:0] alt_pwm [0:10],
    input wire logic [15:0] alt_hw_dir_en [0:10],
    input wire logic [15:0] alt_hw_dir [0:10],
    output logic [15:0] alt_in_r [0:10]
);

    // ==========================================================
    // Unit properties
    // Lines present in a unit
    function automatic logic [15:0] impl_mask(input int u);
        logic [15:0] m;
        m = `MASK_BYTE;
        case (u)
            4: m = `MASK_WORD;
            5: m = `MASK_PORT3;
            7: m = `MASK_WORD;
            default: m = `MASK_BYTE;
        endcase
        return m;
    endfunction

    // Lines that own an output driver
    function automatic logic [15:0] drv_mask(input int u);
        logic [15:0] m;
        m = impl_mask(u);
        if (u == 7)
            m = `MASK_NONE;
        return m;
    endfunction

    // Lines with an open-drain option
    function automatic logic [15:0] od_mask(input int u);
        logic [15:0] m;
        m = `MASK_NONE;
        case (u)
            4, 5, 6, 8, 9, 10: m = impl_mask(u);
            default: m = `MASK_NONE;
        endcase
        return m;
    endfunction

    // ==========================================================
    // Shared state
    logic [`STATE_CNT_W-1:0] state_cnt_r;
    logic state_strobe_r;
    logic [15:0] in_latch [0:10];
    logic [15:0] out_latch_r [0:10];
    logic [15:0] dir_r [0:10];
    logic [15:0] od_r [0:10];
    logic [15:0] rd_val [0:10];
    logic [15:0] rd_sel;

    // ==========================================================
    // State-time strobe
    // Divides clk into state times of two clocks
    // A pin change reaches reads three to four clocks later
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_cnt_r <= '0;
            state_strobe_r <= 1'b0;
        end
        else if (state_cnt_r == `STATE_CNT_W'(`STATE_TIME_CLKS - 1))
        begin
            state_cnt_r <= '0;
            state_strobe_r <= 1'b1;
        end
        else
        begin
            state_cnt_r <= state_cnt_r + `STATE_CNT_W'(1);
            state_strobe_r <= 1'b0;
        end
    end

    // ==========================================================
    // Units: byte halves of ports 0 and 1 are units of their own
    for (genvar u = 0; u < `PIO_UNITS; u++)
    begin : g_unit
        // Line masks of this unit
        localparam logic [15:0] IMPL = impl_mask(u);
        localparam logic [15:0] DRV = drv_mask(u);
        localparam logic [15:0] ODM = od_mask(u);
        // Per-unit working signals
        logic sel;
        logic [15:0] src;
        logic [15:0] new_val;
        logic [15:0] eff_dir;
        logic [15:0] level;

        // Synchroniser and input latch of this unit
        pin_sampler
        #(
            .IMPL_MASK(IMPL)
        )
        u_sampler
        (
            .clk(clk),
            .arst_n(arst_n),
            .state_strobe(state_strobe_r),
            .pad_in(pad_in[u]),
            .in_latch_r(in_latch[u])
        );

        // Writes and read-modify-writes address one unit
        assign sel = acc_valid && (acc_unit == `PIO_UNIT_W'(u))
            && (acc_op != pio_pkg::OP_READ);

        // Read and modify source: pin for inputs, latch for outputs
        always_comb
        begin
            src = (dir_r[u] & out_latch_r[u])
                | (~dir_r[u] & in_latch[u]);
            case (acc_kind)
                pio_pkg::KIND_DATA: rd_val[u] = src & IMPL;
                pio_pkg::KIND_DIR: rd_val[u] = dir_r[u];
                pio_pkg::KIND_OD: rd_val[u] = od_r[u];
                default: rd_val[u] = 16'h0000;
            endcase
            if (acc_op == pio_pkg::OP_RMW)
                new_val = (rd_val[u] & acc_and_mask)
                    | acc_wdata;
            else
                new_val = acc_wdata;
        end

        // Output latch, written whatever the direction
        // Lines without a driver keep a zero latch
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                out_latch_r[u] <= `RST_OUT_LATCH;
            else if (sel && acc_kind == pio_pkg::KIND_DATA)
                out_latch_r[u] <= new_val & DRV;
        end

        // Direction bits, input after reset
        // Input-only lines never take an output direction
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                dir_r[u] <= `RST_DIR;
            else if (sel && acc_kind == pio_pkg::KIND_DIR)
                dir_r[u] <= new_val & DRV;
        end

        // Open-drain select, only where the port supports it
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                od_r[u] <= `RST_OPEN_DRAIN;
            else if (sel && acc_kind == pio_pkg::KIND_OD)
                od_r[u] <= new_val & ODM;
        end

        // Effective direction and driven level
        // Bus functions own the direction while enabled
        always_comb
        begin
            eff_dir = ((alt_hw_dir_en[u] & alt_hw_dir[u])
                | (~alt_hw_dir_en[u] & dir_r[u])) & DRV;
            level = (alt_out_en[u] & alt_pwm[u] & alt_out_data[u])
                | (alt_out_en[u] & ~alt_pwm[u] & alt_out_data[u]
                & out_latch_r[u])
                | (~alt_out_en[u] & out_latch_r[u]);
        end

        // Pad drive, independent of the threshold select
        // Open-drain lines only pull low; the pull-up gives high
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                pad_out_r[u] <= 16'h0000;
                pad_oe_r[u] <= 16'h0000;
            end
            else
            begin
                pad_out_r[u] <= level & DRV;
                pad_oe_r[u] <= eff_dir
                    & (~od_r[u] | ~level);
            end
        end

        // Alternate input: latch loopback when the pin is an output
        // Lets software trigger an alternate input for test
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                alt_in_r[u] <= 16'h0000;
            else
                alt_in_r[u] <= ((eff_dir & out_latch_r[u])
                    | (~eff_dir & in_latch[u])) & IMPL;
        end
    end

    // ==========================================================
    // Read data multiplexer; unmapped units read zero
    // One mux serves reads and write answers
    always_comb
    begin
        rd_sel = 16'h0000;
        for (int i = 0; i < `PIO_UNITS; i++)
        begin
            if (acc_unit == `PIO_UNIT_W'(i))
                rd_sel = rd_val[i];
        end
    end

    // Access answer, one cycle after the request
    // A write returns the value read before it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_done_r <= 1'b0;
            acc_rdata_r <= 16'h0000;
        end
        else
        begin
            acc_done_r <= acc_valid;
            if (acc_valid)
                acc_rdata_r <= rd_sel;
        end
    end

    // ==========================================================
    // Threshold select per byte, low byte in bit 0
    // Byte units leave the upper select bit at TTL
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < `PIO_UNITS; i++)
                cmos_sel_r[i] <= 2'h0;
        end
        else
        begin
            cmos_sel_r[0] <= {1'b0, ext_input_threshold_select[0]};
            cmos_sel_r[1] <= {1'b0, ext_input_threshold_select[1]};
            cmos_sel_r[2] <= {1'b0, ext_input_threshold_select[2]};
            cmos_sel_r[3] <= {1'b0, ext_input_threshold_select[3]};
            cmos_sel_r[4] <= input_threshold_select[1:0];
            cmos_sel_r[5] <= input_threshold_select[3:2];
            cmos_sel_r[6] <= {1'b0, input_threshold_select[4]};
            cmos_sel_r[7] <= ext_input_threshold_select[5:4];
            cmos_sel_r[8] <= {1'b0, input_threshold_select[5]};
            cmos_sel_r[9] <= {1'b0, input_threshold_select[6]};
            cmos_sel_r[10] <= {1'b0, input_threshold_select[7]};
        end
    end

endmodule // pio_port_bank

// ===== pio_consts.svh
// Purpose: Constants for the parallel I/O port bank
// Assumes: 20 MHz clock, state time of two clocks
// Notes: Offsets are unit codes on the access port, not bus addresses
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

// ==========================================================
// Port units
`define PIO_UNITS 11
`define PIO_UNIT_W 4
`define UNIT_PORT_ZERO_LOW_BYTE 4'h0
`define UNIT_PORT_ZERO_HIGH_BYTE 4'h1
`define UNIT_PORT_ONE_LOW_BYTE 4'h2
`define UNIT_PORT_ONE_HIGH_BYTE 4'h3
`define UNIT_PORT2 4'h4
`define UNIT_PORT3 4'h5
`define UNIT_PORT4 4'h6
`define UNIT_PORT5 4'h7
`define UNIT_PORT6 4'h8
`define UNIT_PORT7 4'h9
`define UNIT_PORT8 4'hA

// ==========================================================
// Line masks
`define MASK_BYTE 16'h00FF
`define MASK_WORD 16'hFFFF
`define MASK_PORT3 16'hBFFF
`define MASK_NONE 16'h0000

// ==========================================================
// Reset values
`define RST_OUT_LATCH 16'h0000
`define RST_DIR 16'h0000
`define RST_OPEN_DRAIN 16'h0000

// ==========================================================
// Timing
`define CLK_PERIOD_NS 50
`define STATE_TIME_NS 100
`define STATE_TIME_CLKS \
    ((`STATE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STATE_CNT_W 2

`endif

// ===== pio_pkg.sv
// Purpose: Types for the parallel I/O port bank
// Assumes: Constants come from pio_consts.svh
// Notes: Access operations and register kinds
package pio_pkg;

    // Access operation
    typedef enum logic [1:0]
    {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_RMW = 2'h3
    } acc_op_type;

    // Register selected within a unit
    typedef enum logic [1:0]
    {
        KIND_DATA = 2'h0,
        KIND_DIR = 2'h1,
        KIND_OD = 2'h3
    } acc_kind_type;

endpackage

// ===== pin_sampler.sv
// Purpose: Synchronise pad levels and latch them once per state time
// Assumes: Pads are asynchronous to clk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`include "pio_consts.svh"

module pin_sampler
#(
    parameter logic [15:0] IMPL_MASK = 16'hFFFF
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic state_strobe,
    input wire logic [15:0] pad_in,
    output logic [15:0] in_latch_r
);

    logic [15:0] sync1_r;
    logic [15:0] sync2_r;

    // ==========================================================
    // Two-stage synchroniser
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_r <= 16'h0000;
            sync2_r <= 16'h0000;
        end
        else
        begin
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
        end
    end

    // ==========================================================
    // Input latch, taken each state time regardless of direction
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            in_latch_r <= 16'h0000;
        else if (state_strobe)
            in_latch_r <= sync2_r & IMPL_MASK;
    end

endmodule // pin_sampler

// ===== pio_port_bank_props.sv
// Purpose: Port bank checker
// Assumes: Sees the ports of pio_port_bank only
// Notes: Bound from the testbench top
`timescale 1ns/1ps
module pio_port_bank_props
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic acc_valid,
    input wire logic [3:0] acc_unit,
    input wire pio_pkg::acc_kind_type acc_kind,
    input wire pio_pkg::acc_op_type acc_op,
    input wire logic [15:0] acc_wdata,
    input wire logic [15:0] pad_out_r [0:10],
    input wire logic [15:0] pad_oe_r [0:10],
    input wire logic [15:0] alt_out_en [0:10],
    input wire logic [15:0] alt_out_data [0:10],
    input wire logic [15:0] alt_pwm [0:10],
    input wire logic [15:0] alt_hw_dir_en [0:10],
    input wire logic [15:0] alt_hw_dir [0:10]
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Drive rules
    sequence s_dir_set;
        acc_valid && acc_unit == 4'h0 && acc_kind == pio_pkg::KIND_DIR
            && acc_op == pio_pkg::OP_WRITE && acc_wdata[0];
    endsequence
    property p_dir_drive;
        s_dir_set ##1 !alt_hw_dir_en[0][0] |=> pad_oe_r[0][0];
    endproperty
    a_dir_drive: assert property (p_dir_drive)
        else $error("direction write did not enable driver");
    property p_rst_input;
        $rose(arst_n) |-> (pad_oe_r[4] == 16'h0000) [*2];
    endproperty
    a_rst_input: assert property (p_rst_input)
        else $error("driver on after reset");
    property p_p5_in;
        pad_oe_r[7] == 16'h0000;
    endproperty
    a_p5_in: assert property (p_p5_in)
        else $error("input-only port driven");
    property p_p3_gap;
        !pad_oe_r[5][14];
    endproperty
    a_p3_gap: assert property (p_p3_gap)
        else $error("missing line driven");
    property p_halves;
        pad_oe_r[0][15:8] == 8'h00 && pad_oe_r[1][15:8] == 8'h00;
    endproperty
    a_halves: assert property (p_halves)
        else $error("byte half drives upper lanes");
    property p_hw_dir;
        alt_hw_dir_en[0][0] && !alt_hw_dir[0][0] |=> !pad_oe_r[0][0];
    endproperty
    a_hw_dir: assert property (p_hw_dir)
        else $error("hardware direction ignored");
    property p_alt_and;
        alt_out_en[4][0] && !alt_pwm[4][0] && !alt_out_data[4][0]
            |=> !pad_out_r[4][0];
    endproperty
    a_alt_and: assert property (p_alt_and)
        else $error("alternate data not combined");
    property p_pwm;
        alt_out_en[4][1] && alt_pwm[4][1]
            |=> pad_out_r[4][1] == $past(alt_out_data[4][1]);
    endproperty
    a_pwm: assert property (p_pwm)
        else $error("pulse output gated by latch");
endmodule // pio_port_bank_props

// ===== pio_pad_model.sv
// Purpose: Board and external devices on the pads
// Assumes: Pull-up on every line
// Notes: Wired AND of all drivers
`timescale 1ns/1ps
module pio_pad_model
(
    input wire logic [15:0] pad_out_r [0:10],
    input wire logic [15:0] pad_oe_r [0:10],
    input wire logic [15:0] ext_lvl [0:10],
    input wire logic [15:0] ext_oe [0:10],
    output logic [15:0] pad_in [0:10]
);
    // Released lines float high, any low driver wins
    always_comb
        for (int u = 0; u < 11; u++)
            pad_in[u] = (~pad_oe_r[u] | pad_out_r[u])
                & (~ext_oe[u] | ext_lvl[u]);
endmodule // pio_pad_model

// ===== tb_pio_port_bank.sv
// Purpose: Self-checking bench for the port bank
// Assumes: One-cycle access answer, pull-ups on all pads
// Notes: Unit 4 is the main port under test
`timescale 1ns/1ps
module tb_pio_port_bank;
    logic clk, arst_n, acc_valid, acc_done_r;
    logic [15:0] pad_in [0:10], pad_out_r [0:10], pad_oe_r [0:10];
    logic [15:0] alt_out_en [0:10], alt_out_data [0:10], alt_pwm [0:10];
    logic [15:0] alt_hw_dir_en [0:10], alt_hw_dir [0:10], alt_in_r [0:10];
    logic [15:0] ext_lvl [0:10], ext_oe [0:10];
    logic [1:0] cmos_sel_r [0:10];
    logic [1:0] tw;
    logic [1:0] te [0:11] = '{2'h1, 2'h1, 2'h0, 2'h1, 2'h1, 2'h1, 2'h0,
        2'h2, 2'h1, 2'h0, 2'h1, 2'h0};
    logic [7:0] input_threshold_select;
    logic [5:0] ext_input_threshold_select;
    logic [3:0] acc_unit;
    pio_pkg::acc_kind_type acc_kind;
    pio_pkg::acc_op_type acc_op;
    logic [15:0] acc_wdata, acc_and_mask, acc_rdata_r, rd;
    int error_cnt, checks;
    pio_port_bank uut (.clk, .arst_n, .pad_in, .pad_out_r, .pad_oe_r,
        .cmos_sel_r, .input_threshold_select, .ext_input_threshold_select,
        .acc_valid, .acc_unit, .acc_kind, .acc_op, .acc_wdata,
        .acc_and_mask, .acc_rdata_r, .acc_done_r, .alt_out_en,
        .alt_out_data, .alt_pwm, .alt_hw_dir_en, .alt_hw_dir, .alt_in_r);
    pio_pad_model pads (.pad_out_r, .pad_oe_r, .ext_lvl, .ext_oe, .pad_in);
    // ==========================================================
    // Clock, tasks
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic acc(logic [3:0] u, pio_pkg::acc_kind_type k,
        pio_pkg::acc_op_type o, logic [15:0] w, logic [15:0] m);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_unit <= u;
        acc_kind <= k;
        acc_op <= o;
        acc_wdata <= w;
        acc_and_mask <= m;
        @(posedge clk);
        acc_valid <= 1'b0;
        #1;
        chk("done", {15'h0000, acc_done_r}, 16'h0001);
        rd = acc_rdata_r;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial
    begin
        arst_n = 1'b0;
        acc_valid = 1'b0;
        acc_unit = 4'h0;
        acc_kind = pio_pkg::KIND_DATA;
        acc_op = pio_pkg::OP_READ;
        acc_wdata = 16'h0000;
        acc_and_mask = 16'h0000;
        input_threshold_select = 8'hA5;
        ext_input_threshold_select = 6'h2B;
        for (int u = 0; u < 11; u++)
        begin
            alt_out_en[u] = 16'h0000;
            alt_out_data[u] = 16'h0000;
            alt_pwm[u] = 16'h0000;
            alt_hw_dir_en[u] = 16'h0000;
            alt_hw_dir[u] = 16'h0000;
            ext_lvl[u] = 16'h1234;
            ext_oe[u] = 16'h0000;
        end
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        acc(4'h4, pio_pkg::KIND_DIR, pio_pkg::OP_READ, 16'h0000, 16'h0000);
        chk("dir rst", rd, 16'h0000);
        for (int u = 0; u < 11; u++)
            chk("cmos", 16'(cmos_sel_r[u]), 16'(te[u]));
        ext_oe[4] <= 16'hFFFF;
        acc(4'h4, pio_pkg::KIND_DATA, pio_pkg::OP_WRITE, 16'hABCD, 16'h0000);
        tick(6);
        acc(4'h4, pio_pkg::KIND_DATA, pio_pkg::OP_READ, 16'h0000, 16'h0000);
        chk("in rd", rd, 16'h1234);
        chk("in oe", pad_oe_r[4], 16'h0000);
        acc(4'h4, pio_pkg::KIND_DATA, pio_pkg::OP_RMW, 16'h0000, 16'h00FF);
        chk("rmw in", rd, 16'h1234);
        ext_oe[4] <= 16'h0000;
        acc(4'h4, pio_pkg::KIND_DIR, pio_pkg::OP_WRITE, 16'hFFFF, 16'h0000);
        acc(4'h4, pio_pkg::KIND_DATA, pio_pkg::OP_READ, 16'h0000, 16'h0000);
        chk("latch", rd, 16'h0034);
        chk("out", pad_out_r[4], 16'h0034);
        acc(4'h4, pio_pkg::KIND_DATA, pio_pkg::OP_RMW, 16'h0F00, 16'hFFFF);
        chk("rmw out", rd, 16'h0034);
        acc(4'h4, pio_pkg::KIND_DATA, pio_pkg::OP_READ, 16'h0000, 16'h0000);
        chk("rmw res", rd, 16'h0F34);
        chk("loop", alt_in_r[4], 16'h0F34);
        acc(4'h4, pio_pkg::KIND_OD, pio_pkg::OP_WRITE, 16'h00FF, 16'h0000);
        tick(1);
        chk("od oe", pad_oe_r[4], 16'hFFCB);
        @(posedge clk);
        input_threshold_select <= 8'h5A;
        ext_input_threshold_select <= 6'h14;
        tick(2);
        chk("od thr", pad_oe_r[4], 16'hFFCB);
        for (int u = 0; u < 11; u++)
        begin
            tw = (u == 4 || u == 5 || u == 7) ? 2'h3 : 2'h1;
            chk("cmos inv", 16'(cmos_sel_r[u]), 16'(te[u] ^ tw));
        end
        acc(4'h0, pio_pkg::KIND_OD, pio_pkg::OP_WRITE, 16'hFFFF, 16'h0000);
        acc(4'h0, pio_pkg::KIND_OD, pio_pkg::OP_READ, 16'h0000, 16'h0000);
        chk("no od", rd, 16'h0000);
        acc(4'h0, pio_pkg::KIND_DIR, pio_pkg::OP_WRITE, 16'hFFFF, 16'h0000);
        acc(4'h0, pio_pkg::KIND_DIR, pio_pkg::OP_READ, 16'h0000, 16'h0000);
        chk("half", rd, 16'h00FF);
        acc(4'h1, pio_pkg::KIND_DIR, pio_pkg::OP_READ, 16'h0000, 16'h0000);
        chk("half hi", rd, 16'h0000);
        acc(4'h5, pio_pkg::KIND_DIR, pio_pkg::OP_WRITE, 16'hFFFF, 16'h0000);
        acc(4'h5, pio_pkg::KIND_DIR, pio_pkg::OP_READ, 16'h0000, 16'h0000);
        chk("p3 dir", rd, 16'hBFFF);
        acc(4'h7, pio_pkg::KIND_DIR, pio_pkg::OP_WRITE, 16'hFFFF, 16'h0000);
        acc(4'h7, pio_pkg::KIND_DIR, pio_pkg::OP_READ, 16'h0000, 16'h0000);
        chk("p5 dir", rd, 16'h0000);
        acc(4'hC, pio_pkg::KIND_DATA, pio_pkg::OP_READ, 16'h0000, 16'h0000);
        chk("unmapped", rd, 16'h0000);
        @(posedge clk);
        alt_hw_dir_en[0] <= 16'h0001;
        alt_out_en[6] <= 16'h00FF;
        alt_out_data[6] <= 16'h00FF;
        alt_out_en[4] <= 16'h0007;
        alt_pwm[4] <= 16'h0002;
        alt_out_data[4] <= 16'h0002;
        tick(2);
        chk("hw dir", pad_oe_r[0], 16'h00FE);
        chk("alt hiz", pad_oe_r[6], 16'h0000);
        chk("alt and", pad_out_r[4], 16'h0F32);
        chk("p5 oe", pad_oe_r[7], 16'h0000);
        @(posedge clk);
        arst_n <= 1'b0;
        tick(3);
        chk("rst oe", pad_oe_r[4], 16'h0000);
        @(posedge clk);
        arst_n <= 1'b1;
        acc(4'h4, pio_pkg::KIND_DIR, pio_pkg::OP_READ, 16'h0000, 16'h0000);
        chk("dir rst2", rd, 16'h0000);
        chk("oe rst2", pad_oe_r[4], 16'h0000);
        report_and_stop();
    end
    initial
    begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
endmodule // tb_pio_port_bank
bind pio_port_bank pio_port_bank_props chk_i (.clk, .arst_n, .acc_valid,
    .acc_unit, .acc_kind, .acc_op, .acc_wdata, .pad_out_r, .pad_oe_r,
    .alt_out_en, .alt_out_data, .alt_pwm, .alt_hw_dir_en, .alt_hw_dir);
